// ---- hdl/scr_edge_detect.sv ----
`timescale 1ns/1ps
module scr_edge_detect (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = level;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule // scr_edge_detect

// ---- hdl/scr_pkg.sv ----
package scr_pkg;
  localparam int ADDR_W = 15;
  localparam int CMD_BITS = 16;
  // Register offsets
  localparam logic [14:0] OFF_INTERFACE_CONFIG = 15'h0000;
  localparam logic [14:0] OFF_POWER_MODE_CTRL  = 15'h0002;
  localparam logic [14:0] OFF_MAKER_CODE_LO    = 15'h000C;
  localparam logic [14:0] OFF_MAKER_CODE_HI    = 15'h000D;
  localparam logic [14:0] OFF_STREAM_ADDR_CTRL = 15'h0010;
  localparam logic [14:0] OFF_SYNC_REF_CTRL    = 15'h0029;
  // Reset values
  localparam logic [7:0] RST_INTERFACE_CONFIG = 8'h30;
  localparam logic [7:0] RST_POWER_MODE_CTRL  = 8'h00;
  localparam logic [7:0] RST_STREAM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC_REF_CTRL    = 8'h80;
  // Arbitrary neutral identification value
  localparam logic [15:0] MAKER_CODE_DEFAULT = 16'h5A3C;
  // Field positions
  localparam int IC_SOFT_RESET_BIT  = 7;
  localparam int IC_ASCEND_BIT      = 5;
  localparam int IC_READBACK_BIT    = 4;
  localparam int SA_ADDR_HOLD_BIT   = 0;
  localparam int SR_PROC_EN_BIT     = 6;
  localparam int SR_RECV_EN_BIT     = 5;
  localparam int SR_FINE_STEP_BIT   = 4;
  localparam int SR_DELAY_SEL_HI    = 3;
  localparam int SR_DELAY_SEL_LO    = 0;
  localparam logic [1:0] PWR_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PWR_MODE_DOWN   = 2'h3;
  // Timing
  localparam int CLK_FREQ_MHZ      = 40;
  localparam int SOFT_RESET_NS     = 750;
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS * CLK_FREQ_MHZ + 999) / 1000;
  typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_BUSY} scr_phase_type;
endpackage

// ---- hdl/scr_spi_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - Soft reset bit resets the four writable registers, self-clears.
// - Direction bit one increments, zero decrements.
// - Readback indicator reads one; reads on SDO.
// - Power mode 0 normal, 3 power down.
// - Maker code is fixed read-only 16 bits.
// - Address hold freezes streaming address.
// - Processor enable gates sync events.
// - Receiver enable switches on receiver.
// - Fine step selects smaller window delays.
// - Delay select chooses sampling delay.
module scr_spi_regs #(
  parameter logic [15:0] MAKER_CODE = scr_pkg::MAKER_CODE_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       spiCsN,
  input  wire logic       spiSclk,
  input  wire logic       spiSdi,
  output logic            spiSdo,
  output logic            spiSdoOe,
  input  wire logic       syncRefEvent,
  output logic            syncRefEventOut,
  output logic            chipResetActive,
  output logic            powerDown,
  output logic            syncRefReceiverEn,
  output logic            syncRefProcessorEn,
  output logic            syncWindowFineStep,
  output logic [3:0]      syncDelaySelect
);
  import scr_pkg::*;

  scr_phase_type           phase_r,     phase_nxt;
  logic [3:0]              bitCnt_r,    bitCnt_nxt;
  logic [CMD_BITS-1:0]     shift_r,     shift_nxt;
  logic                    isRead_r,    isRead_nxt;
  logic [ADDR_W-1:0]       addr_r,      addr_nxt;
  logic [7:0]              rdShift_r,   rdShift_nxt;
  logic                    sdo_r,       sdo_nxt;
  logic [5:0]              busyCnt_r,   busyCnt_nxt;
  logic [7:0]              ifCfg_r,     ifCfg_nxt;
  logic [7:0]              pwrMode_r,   pwrMode_nxt;
  logic [7:0]              streamCtl_r, streamCtl_nxt;
  logic [7:0]              syncCtl_r,   syncCtl_nxt;
  logic                    evtOut_r,    evtOut_nxt;
  logic                    sclkRise;
  logic                    sclkFall;
  logic [CMD_BITS-1:0]     cmdWord;
  logic [7:0]              dataByte;
  logic [ADDR_W-1:0]       stepAddr;
  logic [ADDR_W-1:0]       cmdAddr;
  logic                    softReset;

  scr_edge_detect u_sclk_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (spiSclk),
    .rise    (sclkRise),
    .fall    (sclkFall)
  );

  function automatic logic [7:0] readReg(input logic [ADDR_W-1:0] a,
                                         input logic [7:0] ic,
                                         input logic [7:0] pm,
                                         input logic [7:0] sa,
                                         input logic [7:0] sr);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFF_INTERFACE_CONFIG: begin
        v = ic;
        v[IC_SOFT_RESET_BIT] = 1'b0;
        v[IC_READBACK_BIT]   = 1'b1;
      end
      OFF_POWER_MODE_CTRL:  v = pm;
      OFF_MAKER_CODE_LO:    v = MAKER_CODE[7:0];
      OFF_MAKER_CODE_HI:    v = MAKER_CODE[15:8];
      OFF_STREAM_ADDR_CTRL: v = sa;
      OFF_SYNC_REF_CTRL:    v = sr;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  assign cmdWord  = {shift_r[CMD_BITS-2:0], spiSdi};
  assign dataByte = {shift_r[6:0], spiSdi};
  assign cmdAddr  = cmdWord[ADDR_W-1:0];

  always_comb begin
    if (streamCtl_r[SA_ADDR_HOLD_BIT]) begin
      stepAddr = addr_r;
    end else if (ifCfg_r[IC_ASCEND_BIT]) begin
      stepAddr = addr_r + 15'h0001;
    end else begin
      stepAddr = addr_r - 15'h0001;
    end
  end

  // Serial engine and register writes
  always_comb begin
    phase_nxt     = phase_r;
    bitCnt_nxt    = bitCnt_r;
    shift_nxt     = shift_r;
    isRead_nxt    = isRead_r;
    addr_nxt      = addr_r;
    rdShift_nxt   = rdShift_r;
    sdo_nxt       = sdo_r;
    busyCnt_nxt   = busyCnt_r;
    ifCfg_nxt     = ifCfg_r;
    pwrMode_nxt   = pwrMode_r;
    streamCtl_nxt = streamCtl_r;
    syncCtl_nxt   = syncCtl_r;
    softReset     = 1'b0;
    unique case (phase_r)
      PH_BUSY: begin
        if (busyCnt_r == 6'h00) begin
          phase_nxt = PH_CMD;
        end else begin
          busyCnt_nxt = busyCnt_r - 6'h01;
        end
      end
      PH_CMD: begin
        if (spiCsN) begin
          bitCnt_nxt = 4'h0;
        end else if (sclkRise) begin
          shift_nxt  = cmdWord;
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == 4'hF) begin
            phase_nxt   = PH_DATA;
            bitCnt_nxt  = 4'h0;
            isRead_nxt  = cmdWord[CMD_BITS-1];
            addr_nxt    = cmdAddr;
            rdShift_nxt = readReg(cmdAddr, ifCfg_r, pwrMode_r, streamCtl_r, syncCtl_r);
          end
        end
      end
      PH_DATA: begin
        if (spiCsN) begin
          phase_nxt  = PH_CMD;
          bitCnt_nxt = 4'h0;
        end else if (sclkFall) begin
          sdo_nxt     = rdShift_r[7];
          rdShift_nxt = {rdShift_r[6:0], 1'b0};
        end else if (sclkRise) begin
          shift_nxt  = {shift_r[CMD_BITS-2:0], spiSdi};
          bitCnt_nxt = bitCnt_r + 4'h1;
          if (bitCnt_r == 4'h7) begin
            bitCnt_nxt  = 4'h0;
            addr_nxt    = stepAddr;
            rdShift_nxt = readReg(stepAddr, ifCfg_r, pwrMode_r, streamCtl_r, syncCtl_r);
            if (!isRead_r) begin
              unique case (addr_r)
                OFF_INTERFACE_CONFIG: begin
                  ifCfg_nxt = dataByte;
                  ifCfg_nxt[IC_SOFT_RESET_BIT] = 1'b0;
                  ifCfg_nxt[IC_READBACK_BIT]   = 1'b1;
                  softReset = dataByte[IC_SOFT_RESET_BIT];
                end
                OFF_POWER_MODE_CTRL:  pwrMode_nxt   = dataByte;
                OFF_STREAM_ADDR_CTRL: streamCtl_nxt = dataByte;
                OFF_SYNC_REF_CTRL:    syncCtl_nxt   = dataByte;
                default: ;
              endcase
            end
          end
        end
      end
      default: phase_nxt = PH_CMD;
    endcase
    if (softReset) begin
      phase_nxt     = PH_BUSY;
      busyCnt_nxt   = 6'(SOFT_RESET_CYCLES - 1);
      bitCnt_nxt    = 4'h0;
      sdo_nxt       = 1'b0;
      ifCfg_nxt     = RST_INTERFACE_CONFIG;
      pwrMode_nxt   = RST_POWER_MODE_CTRL;
      streamCtl_nxt = RST_STREAM_ADDR_CTRL;
      syncCtl_nxt   = RST_SYNC_REF_CTRL;
    end
  end

  always_comb begin
    evtOut_nxt = syncRefEvent & syncCtl_r[SR_PROC_EN_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_r     <= PH_CMD;
      bitCnt_r    <= 4'h0;
      shift_r     <= 16'h0000;
      isRead_r    <= 1'b0;
      addr_r      <= 15'h0000;
      rdShift_r   <= 8'h00;
      sdo_r       <= 1'b0;
      busyCnt_r   <= 6'h00;
      ifCfg_r     <= RST_INTERFACE_CONFIG;
      pwrMode_r   <= RST_POWER_MODE_CTRL;
      streamCtl_r <= RST_STREAM_ADDR_CTRL;
      syncCtl_r   <= RST_SYNC_REF_CTRL;
      evtOut_r    <= 1'b0;
    end else begin
      phase_r     <= phase_nxt;
      bitCnt_r    <= bitCnt_nxt;
      shift_r     <= shift_nxt;
      isRead_r    <= isRead_nxt;
      addr_r      <= addr_nxt;
      rdShift_r   <= rdShift_nxt;
      sdo_r       <= sdo_nxt;
      busyCnt_r   <= busyCnt_nxt;
      ifCfg_r     <= ifCfg_nxt;
      pwrMode_r   <= pwrMode_nxt;
      streamCtl_r <= streamCtl_nxt;
      syncCtl_r   <= syncCtl_nxt;
      evtOut_r    <= evtOut_nxt;
    end
  end

  // Readback only on the dedicated data-out pin
  assign spiSdo             = sdo_r;
  assign spiSdoOe           = ~spiCsN & (phase_r == PH_DATA) & isRead_r;
  assign chipResetActive    = (phase_r == PH_BUSY);
  assign powerDown          = (pwrMode_r[1:0] == PWR_MODE_DOWN);
  assign syncRefReceiverEn  = syncCtl_r[SR_RECV_EN_BIT];
  assign syncRefProcessorEn = syncCtl_r[SR_PROC_EN_BIT];
  assign syncWindowFineStep = syncCtl_r[SR_FINE_STEP_BIT];
  assign syncDelaySelect    = syncCtl_r[SR_DELAY_SEL_HI:SR_DELAY_SEL_LO];
  assign syncRefEventOut    = evtOut_r;
endmodule // scr_spi_regs

// ---- testbench/scr_spi_host.sv ----
`timescale 1ns/1ps
module scr_spi_host (
  input  wire logic ref_clk,
  input  wire logic spiSdo,
  output logic      spiCsN,
  output logic      spiSclk,
  output logic      spiSdi
);
  initial begin
    spiCsN = 1'b1;
    spiSclk = 1'b0;
    spiSdi = 1'b0;
  end
  // Mode 0 frame, bytes wd, wd+1, ...; keeps the last 16 bits read
  task automatic frame(input logic [15:0] cmd, input int n, input logic [7:0] wd,
                       output logic [15:0] rq);
    logic [7:0] w;
    rq = 16'h0000;
    spiCsN <= 1'b0;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      w = wd + 8'((i - 16) >>> 3);
      spiSclk <= 1'b0;
      spiSdi <= (i < 16) ? cmd[15 - i] : w[7 - i % 8];
      repeat (4) @(posedge ref_clk);
      if (i >= 16) rq = {rq[14:0], spiSdo};
      spiSclk <= 1'b1;
      repeat (2) @(posedge ref_clk);
    end
    spiSclk <= 1'b0;
    repeat (2) @(posedge ref_clk);
    spiCsN <= 1'b1;
    // Released line shows no stale bit
    spiSdi <= ~spiSdi;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // scr_spi_host

// ---- testbench/scr_spi_regs_monitor.sv ----
`timescale 1ns/1ps
module scr_spi_regs_monitor (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       spiCsN,
  input wire logic       spiSdoOe,
  input wire logic       syncRefEvent,
  input wire logic       syncRefEventOut,
  input wire logic       chipResetActive,
  input wire logic       powerDown,
  input wire logic       syncRefReceiverEn,
  input wire logic       syncRefProcessorEn,
  input wire logic       syncWindowFineStep,
  input wire logic [3:0] syncDelaySelect
);
  logic [7:0] actCnt_r;
  logic [7:0] actCnt_nxt;
  logic       idle;
  always_comb begin
    actCnt_nxt = chipResetActive ? actCnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk) begin
    actCnt_r <= rst ? 8'h00 : actCnt_nxt;
  end
  assign idle = spiCsN && !chipResetActive;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_event_gated: assert property (syncRefEventOut == $past(syncRefEvent & syncRefProcessorEn))
    else $error("sync event output not gated");
  a_soft_length: assert property ($fell(chipResetActive) |-> actCnt_r == 8'h1E)
    else $error("soft reset length wrong");
  a_soft_clears: assert property ($rose(chipResetActive) |-> ##[0:1] (!powerDown &&
    !syncRefReceiverEn && !syncRefProcessorEn && !syncWindowFineStep && syncDelaySelect == 4'h0))
    else $error("soft reset left settings");
  a_oe_deselect: assert property (spiCsN |-> !spiSdoOe)
    else $error("readback driven while deselected");
  a_oe_command: assert property ($fell(spiCsN) |-> !spiSdoOe [*8])
    else $error("readback driven in command");
  a_soft_quiet: assert property (chipResetActive |-> !spiSdoOe)
    else $error("readback driven during soft reset");
  a_sel_steady: assert property (idle && $past(idle) |-> $stable({syncWindowFineStep,
    syncDelaySelect})) else $error("delay settings moved while idle");
  a_rx_steady: assert property (idle && $past(idle) |-> $stable(syncRefReceiverEn))
    else $error("receiver enable moved while idle");
  a_power_steady: assert property (idle && $past(idle) |-> $stable(powerDown))
    else $error("power mode moved while idle");
endmodule // scr_spi_regs_monitor
bind scr_spi_regs scr_spi_regs_monitor i_mon (.ref_clk(ref_clk), .rst(rst), .spiCsN(spiCsN),
  .spiSdoOe(spiSdoOe), .syncRefEvent(syncRefEvent), .syncRefEventOut(syncRefEventOut),
  .chipResetActive(chipResetActive), .powerDown(powerDown),
  .syncRefReceiverEn(syncRefReceiverEn), .syncRefProcessorEn(syncRefProcessorEn),
  .syncWindowFineStep(syncWindowFineStep), .syncDelaySelect(syncDelaySelect));

// ---- testbench/tb_scr_spi_regs.sv ----
`timescale 1ns/1ps
module tb_scr_spi_regs;
  import scr_pkg::*;
  localparam logic [15:0] MC = 16'hA5C3; // Arbitrary identification value
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        spiCsN, spiSclk, spiSdi, spiSdo, spiSdoOe, syncRefEventOut, chipResetActive;
  logic        syncRefEvent = 1'b0;
  logic        powerDown, syncRefReceiverEn, syncRefProcessorEn, syncWindowFineStep;
  logic [3:0]  syncDelaySelect;
  logic [15:0] rq;
  logic [7:0]  v;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          oeCnt = 0;
  int          oeRef = 0;
  int          seed = 32'hced3;
  scr_spi_regs #(.MAKER_CODE(MC)) i_dut (.ref_clk(ref_clk), .rst(rst), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
    .syncRefEvent(syncRefEvent), .syncRefEventOut(syncRefEventOut),
    .chipResetActive(chipResetActive), .powerDown(powerDown),
    .syncRefReceiverEn(syncRefReceiverEn), .syncRefProcessorEn(syncRefProcessorEn),
    .syncWindowFineStep(syncWindowFineStep), .syncDelaySelect(syncDelaySelect));
  scr_spi_host i_host (.ref_clk(ref_clk), .spiSdo(spiSdo), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiSdi(spiSdi));
  always #12.5 ref_clk = ~ref_clk;
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    syncRefEvent <= 1'($random(seed));
    cyc <= cyc + 1;
    if (spiSdoOe) oeCnt <= oeCnt + 1;
    if (cyc == 30000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d, input int n = 1);
    i_host.frame({1'b0, a}, n, d, rq);
  endtask
  task automatic rd(input logic [14:0] a, input int n = 1);
    i_host.frame({1'b1, a}, n, 8'h00, rq);
  endtask
  // Readback of the interface register after writing w
  function automatic logic [7:0] ic_exp(input logic [7:0] w);
    return {1'b0, w[6:5], 1'b1, w[3:0]};
  endfunction
  logic [14:0] ta[4] = '{OFF_INTERFACE_CONFIG, OFF_POWER_MODE_CTRL, OFF_STREAM_ADDR_CTRL,
                         OFF_SYNC_REF_CTRL};
  logic [7:0]  tr[4] = '{8'h30, 8'h00, 8'h00, 8'h80};
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      rd(ta[i]);
      chk(rq[7:0], tr[i]);
    end
    chk(oeCnt != 0, 1'b1);
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hFF : 8'($random(seed)) | 8'h80;
      if (v[6]) v[5] = 1'b1;
      wr(OFF_SYNC_REF_CTRL, v & 8'hBF);
      wr(OFF_SYNC_REF_CTRL, v);
      chk({syncRefProcessorEn, syncRefReceiverEn, syncWindowFineStep, syncDelaySelect}, v[6:0]);
      rd(OFF_SYNC_REF_CTRL);
      chk(rq[7:0], v);
    end
    oeRef = oeCnt;
    for (int m = 0; m < 4; m++) begin
      wr(OFF_POWER_MODE_CTRL, 8'(m));
      chk(powerDown, m == 3);
    end
    chk(oeCnt - oeRef, 16'h0000);
    wr(OFF_MAKER_CODE_LO, 8'h00, 2);
    rd(OFF_MAKER_CODE_LO, 2);
    chk(rq, {MC[7:0], MC[15:8]});
    wr(OFF_INTERFACE_CONFIG, 8'h00);
    rd(OFF_INTERFACE_CONFIG);
    chk(rq[7:0], ic_exp(8'h00));
    rd(OFF_MAKER_CODE_HI, 2);
    chk(rq, MC);
    wr(OFF_STREAM_ADDR_CTRL, 8'h01);
    wr(OFF_SYNC_REF_CTRL, 8'hA1, 3);
    chk(syncDelaySelect, 4'h3);
    rd(OFF_MAKER_CODE_LO, 2);
    chk(rq, {MC[7:0], MC[7:0]});
    rd(15'h0040);
    chk(rq[7:0], 8'h00);
    wr(OFF_POWER_MODE_CTRL, 8'h03);
    wr(OFF_INTERFACE_CONFIG, 8'h80);
    chk(chipResetActive, 1'b1);
    for (int t = 0; t < 40 && chipResetActive !== 1'b0; t++) @(posedge ref_clk);
    chk(chipResetActive, 1'b0);
    chk(powerDown, 1'b0);
    rd(OFF_INTERFACE_CONFIG);
    chk(rq[7:0], RST_INTERFACE_CONFIG);
    rd(OFF_STREAM_ADDR_CTRL);
    chk(rq[7:0], RST_STREAM_ADDR_CTRL);
    give_verdict();
  end
endmodule // tb_scr_spi_regs
